// ==== gpio_port_defs.vh ====
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

`define ADDR_PIN_LATCH_BANK_A 8'h80
`define ADDR_PIN_LATCH_BANK_B 8'h90
`define ADDR_PIN_LATCH_BANK_C 8'hA0
`define ADDR_FALL_EDGE_FLAGS 8'hAD
`define ADDR_PIN_LATCH_BANK_D 8'hB0

`define RST_PIN_LATCH 8'hFF
`define RST_FALL_EDGE_FLAGS 8'h00
`define FALL_FLAG_MASK 8'hF0
`define FALL_FLAG_LSB 4
`define PORT_WIDTH 8
`define PORT_COUNT 4

`define RMW_NONE 1'b0
`define RMW_LATCH 1'b1

`endif

// ==== pin_driver.v ====
`default_nettype none
`include "gpio_port_defs.vh"

// Output stage of one byte-wide port
module pin_driver (
  input wire [7:0] i_latch,
  input wire [7:0] i_push_pull,
  input wire i_weak_pullup_en,
  output wire [7:0] o_pin_out,
  output wire [7:0] o_pin_oe,
  output wire [7:0] o_pullup_en
);

  // A 1 in open-drain mode releases the pin
  assign o_pin_out = i_latch;
  assign o_pin_oe = ~i_latch | i_push_pull;
  // Pull-up holds released pins, also on ports with no pins
  assign o_pullup_en = {8{i_weak_pullup_en}} & ~o_pin_oe;

endmodule
`default_nettype wire

// ==== fall_edge_detect.v ====
`default_nettype none
`include "gpio_port_defs.vh"

// Sticky falling-edge flags for the upper half of the second port
module fall_edge_detect (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [3:0] i_pin,
  input wire [3:0] i_clear,
  output wire [3:0] o_flags
);

  reg [3:0] pin_prev_q;
  reg [3:0] flags_q;
  reg [3:0] flags_d;
  reg [1:0] arm_q;
  wire [3:0] fall;

  // Pins held low through reset must not look like a falling edge, so
  // detection waits until both compared samples are real pin levels
  assign fall = arm_q[1] ? (pin_prev_q & ~i_pin) : 4'h0;
  assign o_flags = flags_q;

  always @* begin
    // A new edge in the clear cycle wins so it is not lost
    flags_d = (flags_q & ~i_clear) | fall;
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_prev_q <= 4'hF;
      flags_q <= 4'h0;
      arm_q <= 2'b00;
    end else begin
      arm_q <= {arm_q[0], 1'b1};
      pin_prev_q <= i_pin;
      flags_q <= flags_d;
    end
  end

endmodule
`default_nettype wire

// ==== general_purpose_port_io.v ====
`default_nettype none
`include "gpio_port_defs.vh"

module general_purpose_port_io (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire i_sfr_bit,
  input wire [2:0] i_sfr_bit_sel,
  input wire i_sfr_rmw,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  output wire o_sfr_hit,
  input wire i_weak_pullup_en,
  input wire [31:0] i_push_pull,
  input wire [31:0] i_pin_in,
  output wire [31:0] o_pin_out,
  output wire [31:0] o_pin_oe,
  output wire [31:0] o_pullup_en
);

  reg [7:0] latch_q [0:3];
  reg [7:0] pin_sync_q [0:3];
  reg [3:0] flag_clear;
  reg [7:0] flag_wr_val;
  reg [7:0] rd_val;
  wire [3:0] flags;
  wire [3:0] port_hit;
  wire flag_hit;

  // Port index decode, used for hit and read select
  function [2:0] port_index;
    input [7:0] addr;
    begin
      if (addr == `ADDR_PIN_LATCH_BANK_A) begin
        port_index = 3'd0;
      end else if (addr == `ADDR_PIN_LATCH_BANK_B) begin
        port_index = 3'd1;
      end else if (addr == `ADDR_PIN_LATCH_BANK_C) begin
        port_index = 3'd2;
      end else if (addr == `ADDR_PIN_LATCH_BANK_D) begin
        port_index = 3'd3;
      end else begin
        port_index = 3'd4;
      end
    end
  endfunction

  // Merge a write into an old byte, whole or one bit
  function [7:0] merge;
    input [7:0] old;
    input [7:0] wdata;
    input bit_mode;
    input [2:0] sel;
    reg [7:0] tmp;
    begin
      tmp = old;
      if (bit_mode) begin
        tmp[sel] = wdata[0];
      end else begin
        tmp = wdata;
      end
      merge = tmp;
    end
  endfunction

  assign flag_hit = (i_sfr_addr == `ADDR_FALL_EDGE_FLAGS);
  assign o_sfr_hit = (port_index(i_sfr_addr) != 3'd4) | flag_hit;

  genvar g;
  generate
    for (g = 0; g < `PORT_COUNT; g = g + 1) begin : g_port
      assign port_hit[g] = (port_index(i_sfr_addr) == g);

      // Latch exists for every port, pinned out or not
      always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          latch_q[g] <= `RST_PIN_LATCH;
          pin_sync_q[g] <= `RST_PIN_LATCH;
        end else begin
          pin_sync_q[g] <= i_pin_in[g*8 +: 8];
          if (i_sfr_wr && port_hit[g]) begin
            latch_q[g] <= merge(latch_q[g], i_sfr_wdata, i_sfr_bit,
                                i_sfr_bit_sel);
          end
        end
      end

      pin_driver u_drv (
        .i_latch(latch_q[g]),
        .i_push_pull(i_push_pull[g*8 +: 8]),
        .i_weak_pullup_en(i_weak_pullup_en),
        .o_pin_out(o_pin_out[g*8 +: 8]),
        .o_pin_oe(o_pin_oe[g*8 +: 8]),
        .o_pullup_en(o_pullup_en[g*8 +: 8])
      );
    end
  endgenerate

  // Flag clear: writing 0 clears; in bit mode only the addressed bit
  always @* begin
    flag_wr_val = merge({flags, 4'h0}, i_sfr_wdata, i_sfr_bit,
                        i_sfr_bit_sel);
    flag_clear = (i_sfr_wr && flag_hit) ? ~flag_wr_val[7:4] : 4'h0;
  end

  fall_edge_detect u_fall (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(pin_sync_q[1][7:4]),
    .i_clear(flag_clear),
    .o_flags(flags)
  );

  // Read: pins normally, latch for read-modify-write
  always @* begin
    rd_val = 8'h00;
    if (flag_hit) begin
      rd_val = {flags, 4'h0};
    end else if (o_sfr_hit) begin
      case (port_index(i_sfr_addr))
        3'd0: rd_val = i_sfr_rmw ? latch_q[0] : pin_sync_q[0];
        3'd1: rd_val = i_sfr_rmw ? latch_q[1] : pin_sync_q[1];
        3'd2: rd_val = i_sfr_rmw ? latch_q[2] : pin_sync_q[2];
        default: rd_val = i_sfr_rmw ? latch_q[3] : pin_sync_q[3];
      endcase
    end
    if (i_sfr_bit) begin
      rd_val = {7'h00, rd_val[i_sfr_bit_sel]};
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_val;
    end
  end

endmodule
`default_nettype wire

// ==== gpio_port_chk.sv ====
`default_nettype none
module gpio_port_chk (
  input wire logic i_sys_clk, i_rstn, i_sfr_wr, i_sfr_rd, i_sfr_bit,
  input wire logic i_sfr_rmw, o_sfr_hit,
  input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
  input wire logic [31:0] i_push_pull, i_pin_in, o_pin_out, o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire logic brd = i_sfr_rd && !i_sfr_bit;
  a_wr_latch: assert property (i_sfr_wr && !i_sfr_bit &&
    i_sfr_addr == 8'h80 |=> o_pin_out[7:0] == $past(i_sfr_wdata))
    else $error("latch write");
  a_latch_hold: assert property (!i_sfr_wr |=> $stable(o_pin_out))
    else $error("latch moved");
  a_oe_mode: assert property (o_pin_oe == (~o_pin_out | i_push_pull))
    else $error("drive enable");
  a_pin_read: assert property (brd && !i_sfr_rmw && i_sfr_addr == 8'h80
    |=> o_sfr_rdata == $past(i_pin_in[7:0], 2)) else $error("pin read");
  a_rmw_latch: assert property (brd && i_sfr_rmw && !i_sfr_wr &&
    i_sfr_addr == 8'h90 |=> o_sfr_rdata == o_pin_out[15:8])
    else $error("rmw read");
  a_flag_low: assert property (brd && i_sfr_addr == 8'hAD
    |=> o_sfr_rdata[3:0] == 4'h0) else $error("flag low bits");
  a_bad_read: assert property (i_sfr_rd && !o_sfr_hit
    |=> o_sfr_rdata == 8'h00) else $error("unmapped read");
  a_rd_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved");
  c_bit_wr: cover property (i_sfr_wr && i_sfr_bit);
  c_rmw: cover property (i_sfr_rd && i_sfr_rmw);
  c_flag: cover property (i_sfr_rd && i_sfr_addr == 8'hAD);
endmodule
bind general_purpose_port_io gpio_port_chk u_gpio_port_chk (.*);
`default_nettype wire

// ==== gpio_port_ext.sv ====
`default_nettype none
module gpio_port_ext (
  input wire logic [31:0] i_pin_out,
  input wire logic [31:0] i_pin_oe,
  input wire logic [31:0] i_pullup_en,
  input wire logic [31:0] i_drv,
  input wire logic [31:0] i_drv_en,
  output logic [31:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating unpulled pin shows the inverse, so stale levels never pass
  always_comb
    for (int i = 0; i < 32; i++)
      o_pin[i] = i_pin_oe[i] ? i_pin_out[i] : i_drv_en[i] ? i_drv[i] :
        i_pullup_en[i] | ~i_drv[i];
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rstn, i_sfr_wr, i_sfr_rd, i_sfr_bit, i_sfr_rmw;
  logic i_weak_pullup_en, o_sfr_hit;
  logic [2:0] i_sfr_bit_sel;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
  logic [31:0] i_push_pull, i_pin_in, o_pin_out, o_pin_oe, o_pullup_en;
  logic [31:0] drv, den;
  int error_cnt, compares, cyc;
  general_purpose_port_io u_general_purpose_port_io (.*);
  gpio_port_ext u_gpio_port_ext (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_drv(drv), .i_drv_en(den), .o_pin(i_pin_in));
  task chk(input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, d, input logic [4:0] m,
      input logic [7:0] e);
    @(posedge i_sys_clk);
    {i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} <= {w, !w, a, d};
    {i_sfr_rmw, i_sfr_bit, i_sfr_bit_sel} <= m;
    @(posedge i_sys_clk);
    {i_sfr_wr, i_sfr_rd} <= 2'b00;
    #1;
    if (!w) chk({24'h0, o_sfr_rdata}, e);
  endtask
  task close_out;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    i_sys_clk = 0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // Expected run is about 50 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    {i_rstn, i_sfr_wr, i_sfr_rd, i_sfr_bit, i_sfr_rmw, i_sfr_bit_sel} = '0;
    {i_sfr_addr, i_sfr_wdata, i_push_pull} = '0;
    i_weak_pullup_en = 1;
    drv = 32'h3CF5960F;
    den = '1;
    repeat (10) @(posedge i_sys_clk);
    i_rstn <= 1;
    #1;
    chk(o_pin_out, 32'hFFFFFFFF);
    chk(o_pullup_en, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
      acc(0, {2'b10, i[1:0], 4'h0}, 0, 0, drv[8*i+:8]);
    acc(0, 8'h90, 0, 5'h10, 8'hFF);
    acc(0, 8'h90, 0, 5'h0E, {7'h0, drv[14]});
    // Pins 6 and 5 of the second port sit low through reset: no flag
    acc(0, 8'hAD, 0, 0, 8'h00);
    @(posedge i_sys_clk);
    drv[15:8] <= 8'h05;
    repeat (3) @(posedge i_sys_clk);
    acc(0, 8'hAD, 0, 0, 8'h90);
    acc(1, 8'hAD, 8'h7F, 0, 0);
    acc(0, 8'hAD, 0, 0, 8'h10);
    for (int i = 0; i < 4; i++)
      acc(1, {2'b10, i[1:0], 4'h0}, 8'hC3 + i[7:0], 0, 0);
    chk(o_pin_out, 32'hC6C5C4C3);
    chk(o_pin_oe, 32'h393A3B3C);
    chk(o_pullup_en, 32'hC6C5C4C3);
    @(posedge i_sys_clk);
    i_push_pull <= 32'hFF000000;
    acc(1, 8'h80, 8'h01, 5'h0A, 0);
    chk(o_pin_oe, 32'hFF3A3B38);
    acc(1, 8'h81, 8'h00, 0, 0);
    acc(0, 8'h81, 0, 0, 8'h00);
    chk({31'h0, o_sfr_hit}, 32'h0);
    chk(o_pin_out, 32'hC6C5C4C7);
    acc(0, 8'h90, 0, 0, 8'h04);
    chk({31'h0, o_sfr_hit}, 32'h1);
    close_out;
  end
endmodule
`default_nettype wire
